/* include/wwdt_pkg.sv */
// Shared constants, layouts and helpers of the windowed watchdog
package wwdt_pkg;
  // Clock rates and watchdog tick divider
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned WDT_HZ = 17_250;
  localparam int unsigned TICK_DIV = CLK_HZ / WDT_HZ;

  // Bus and counter widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_OPTION = 8'h00;
  localparam logic [7:0] OFS_CLEAR = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;

  localparam logic [7:0] CLEAR_KEY = 8'hAC;

  typedef struct packed {
    logic interval_irq_enable;
    logic window_sel_hi;
    logic window_sel_lo;
    logic standby_count_enable;
    logic reserved;
    logic overflow_sel_bit2;
    logic overflow_sel_bit1;
    logic overflow_sel_bit0;
  } wwdt_option_s;

  typedef struct packed {
    logic violation;
    logic overflow;
    logic interval;
  } wwdt_status_s;

  // Reset values and writable bits
  localparam logic [7:0] OPTION_RST = 8'h77;
  localparam logic [7:0] OPTION_WR_MASK = 8'hF7;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;

  // Overflow exponent per three-bit select code
  function automatic logic [4:0] ovf_exp(input logic [2:0] sel);
    logic [4:0] e;
    case (sel)
      3'h0: e = 5'h06;
      3'h1: e = 5'h07;
      3'h2: e = 5'h08;
      3'h3: e = 5'h09;
      3'h4: e = 5'h0B;
      3'h5: e = 5'h0D;
      3'h6: e = 5'h0E;
      default: e = 5'h10;
    endcase
    return e;
  endfunction
endpackage

/* src/wwdt_tick.sv */
// Watchdog clock tick and half-tick pulse generator
`timescale 1ns/10ps
`default_nettype none
module wwdt_tick #(
  parameter int unsigned DIV = wwdt_pkg::TICK_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pulses, one per watchdog period each
  output logic tick,
  output logic half
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  localparam logic [W-1:0] MID = W'(DIV / 2);

  logic [W-1:0] phase_r;
  logic [W-1:0] phase_nxt;
  logic tick_r;
  logic tick_nxt;
  logic half_r;
  logic half_nxt;

  always_comb
  begin
    phase_nxt = (phase_r == LAST) ? '0 : phase_r + 1'b1;
    tick_nxt = (phase_r == LAST);
    // Half pulse marks the middle of a watchdog period
    half_nxt = (phase_r == MID);
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      phase_r <= '0;
      tick_r <= 1'b0;
      half_r <= 1'b0;
    end
    else
    begin
      phase_r <= phase_nxt;
      tick_r <= tick_nxt;
      half_r <= half_nxt;
    end
  end

  assign tick = tick_r;
  assign half = half_r;
endmodule
`default_nettype wire

/* src/wwdt_top.sv */
// Windowed watchdog timer with register port and interrupt
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - With interval enabled and its mask bit set, interrupt fires at 75% of overflow plus half tick.
// - Two window select bits set the length of the open window while standby counting is enabled.
// - Three select bits pick overflow of 2^6..2^16 ticks; overflow requests reset.
// - Standby counting bit keeps or stops the counter in standby.
// - Writing the key to the clear register zeroes the counter.
// - With interval enabled, interval flag goes to one at 75% plus half tick.
module wwdt_top #(
  parameter int unsigned TICK_DIV = wwdt_pkg::TICK_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [wwdt_pkg::ADDR_W-1:0] addr,
  input wire logic [wwdt_pkg::DATA_W-1:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [wwdt_pkg::DATA_W-1:0] rdata,
  // Chip state and results
  input wire logic standby,
  output logic irq,
  output logic wdt_reset
);
  localparam int CW = wwdt_pkg::CNT_W;

  logic tick;
  logic half;
  wwdt_pkg::wwdt_option_s opt_r;
  wwdt_pkg::wwdt_option_s opt_nxt;
  wwdt_pkg::wwdt_status_s status_r;
  wwdt_pkg::wwdt_status_s status_nxt;
  logic [2:0] mask_r;
  logic [2:0] mask_nxt;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic [wwdt_pkg::DATA_W-1:0] rdata_r;
  logic [wwdt_pkg::DATA_W-1:0] rdata_nxt;
  logic irq_r;
  logic irq_nxt;
  logic wdt_reset_r;
  logic wdt_reset_nxt;

  logic [CW:0] limit;
  logic [CW:0] quarter;
  logic [CW:0] thr;
  logic [CW:0] closed_lim;
  logic [CW:0] cnt_ext;
  logic [1:0] closed_q;
  logic run;
  logic key_wr;
  logic closed;
  logic violation_ev;
  logic clear_ev;
  logic ovf_ev;
  logic int_ev;

  wwdt_tick #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk(clk),
    .reset(reset),
    .tick(tick),
    .half(half)
  );

  always_comb
  begin
    cnt_ext = {1'b0, count_r};
    limit = {{CW{1'b0}}, 1'b1} << wwdt_pkg::ovf_exp({opt_r.overflow_sel_bit2,
      opt_r.overflow_sel_bit1, opt_r.overflow_sel_bit0});
    quarter = limit >> 2;
    thr = quarter + {quarter[CW-1:0], 1'b0};
    // Closed part covers the quarters not opened by the select code
    closed_q = 2'h3 - {opt_r.window_sel_hi, opt_r.window_sel_lo};
    closed_lim = (closed_q[0] ? quarter : '0) + (closed_q[1] ? {quarter[CW-1:0], 1'b0} : '0);
    run = !standby || opt_r.standby_count_enable;
    key_wr = we && (addr == wwdt_pkg::OFS_CLEAR) && (wdata[7:0] == wwdt_pkg::CLEAR_KEY);
    // Window only has force while counting in standby is enabled
    closed = opt_r.standby_count_enable && (cnt_ext < closed_lim);
    violation_ev = key_wr && closed;
    clear_ev = key_wr && !closed;
    ovf_ev = tick && run && (cnt_ext == limit - 1'b1);
    int_ev = half && run && (cnt_ext == thr) && opt_r.interval_irq_enable;
  end

  always_comb
  begin
    opt_nxt = opt_r;
    mask_nxt = mask_r;
    status_nxt = status_r;
    count_nxt = count_r;
    rdata_nxt = '0;
    if (we && addr == wwdt_pkg::OFS_OPTION)
      opt_nxt = wdata[7:0] & wwdt_pkg::OPTION_WR_MASK;
    if (we && addr == wwdt_pkg::OFS_MASK)
      mask_nxt = wdata[2:0];
    if (violation_ev || ovf_ev || clear_ev)
      count_nxt = '0;
    else if (tick && run)
      count_nxt = count_r + 1'b1;
    if (re && addr == wwdt_pkg::OFS_STATUS)
      status_nxt = '0;
    if (violation_ev || ovf_ev || clear_ev)
      status_nxt.interval = 1'b0;
    // Sets come last so an event in a clearing cycle is kept
    if (int_ev)
      status_nxt.interval = 1'b1;
    if (ovf_ev)
      status_nxt.overflow = 1'b1;
    if (violation_ev)
      status_nxt.violation = 1'b1;
    if (re)
    begin
      case (addr)
        wwdt_pkg::OFS_OPTION: rdata_nxt = {8'h00, opt_r};
        wwdt_pkg::OFS_STATUS: rdata_nxt = {13'h0000, status_r};
        wwdt_pkg::OFS_MASK: rdata_nxt = {13'h0000, mask_r};
        wwdt_pkg::OFS_COUNT: rdata_nxt = count_r;
        default: rdata_nxt = '0;
      endcase
    end
    irq_nxt = |(status_nxt & mask_nxt);
    wdt_reset_nxt = violation_ev || ovf_ev;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      opt_r <= wwdt_pkg::OPTION_RST;
      mask_r <= wwdt_pkg::MASK_RST;
      status_r <= wwdt_pkg::STATUS_RST;
      count_r <= wwdt_pkg::COUNT_RST;
      rdata_r <= '0;
      irq_r <= 1'b0;
      wdt_reset_r <= 1'b0;
    end
    else
    begin
      opt_r <= opt_nxt;
      mask_r <= mask_nxt;
      status_r <= status_nxt;
      count_r <= count_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      wdt_reset_r <= wdt_reset_nxt;
    end
  end

  assign rdata = rdata_r;
  assign irq = irq_r;
  assign wdt_reset = wdt_reset_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_key_open;
    key_wr && !closed && !ovf_ev;
  endsequence

  sequence s_key_closed;
    key_wr && closed;
  endsequence

  property p_interval_set;
    (half && run && cnt_ext == thr && opt_r.interval_irq_enable) |=> status_r.interval;
  endproperty
  a_interval_set: assert property (p_interval_set)
    else $error("interval flag not set at threshold");

  property p_full_window;
    (key_wr && {opt_r.window_sel_hi, opt_r.window_sel_lo} == 2'h3 && !ovf_ev) |=> !wdt_reset_r;
  endproperty
  a_full_window: assert property (p_full_window)
    else $error("full window still flagged a violation");

  property p_overflow;
    (tick && run && cnt_ext == limit - 1'b1) |=> (wdt_reset_r && count_r == '0);
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow did not request reset");

  property p_standby_hold;
    (standby && !opt_r.standby_count_enable && !key_wr) |=> $stable(count_r);
  endproperty
  a_standby_hold: assert property (p_standby_hold)
    else $error("counter moved in standby");

  property p_key_clear;
    s_key_open |=> (count_r == '0 && !wdt_reset_r);
  endproperty
  a_key_clear: assert property (p_key_clear)
    else $error("key write did not clear counter");

  property p_flag_cause;
    $rose(status_r.interval) |->
      ($past(cnt_ext) == $past(thr) && $past(opt_r.interval_irq_enable));
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("interval flag set without cause");

  property p_closed_violation;
    s_key_closed |=> (wdt_reset_r && status_r.violation) ##1 !wdt_reset_r;
  endproperty
  a_closed_violation: assert property (p_closed_violation)
    else $error("closed window key write missed");

  property p_flag_cleared;
    (s_key_open and !int_ev) |=> !status_r.interval;
  endproperty
  a_flag_cleared: assert property (p_flag_cleared)
    else $error("interval flag survived counter clear");

  property p_irq_level;
    ##1 (irq_r == |(status_r & mask_r));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("irq does not follow masked status");
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking testbench of the windowed watchdog
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // Short tick divider keeps the longest wait near four hundred cycles
  localparam int unsigned DIV = 8;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic we = 1'b0;
  logic re = 1'b0;
  logic standby = 1'b0;
  logic [15:0] rdata;
  logic irq;
  logic wdt_reset;
  int n_fail = 0;
  int checks = 0;
  int n;
  logic [15:0] d;
  logic [15:0] keep;

  always #50 clk = ~clk;

  wwdt_top #(.TICK_DIV(DIV)) dut_u (
    .clk(clk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .we(we),
    .re(re),
    .rdata(rdata),
    .standby(standby),
    .irq(irq),
    .wdt_reset(wdt_reset)
  );

  task automatic print_verdict();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  task automatic wait_sig(input bit pick, input int max, output int cnt);
    cnt = 0;
    do
    begin
      @(negedge clk);
      cnt++;
    end
    while ((pick ? wdt_reset : irq) !== 1'b1 && cnt < max);
    if ((pick ? wdt_reset : irq) !== 1'b1)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      print_verdict();
    end
  endtask

  task automatic scen_reset_values();
    rd(8'h00, d);
    chk(d, 16'h0077);
    rd(8'h0C, d);
    chk(d, 16'h0000);
    rd(8'h08, d);
    chk(d, 16'h0000);
    rd(8'h20, d);
    chk(d, 16'h0000);
    wr(8'h00, 16'h00FF);
    rd(8'h00, d);
    chk(d, 16'h00F7);
  endtask

  // Interval at 48 of 64 ticks, then overflow reset
  task automatic scen_interval_overflow();
    wr(8'h00, 16'h00F0);
    wr(8'h0C, 16'h0001);
    wr(8'h04, 16'h00AC);
    wait_sig(1'b0, 420, n);
    chk({15'h0000, n >= 376 && n <= 400}, 16'h0001);
    rd(8'h08, d);
    chk(d, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    wait_sig(1'b1, 160, n);
    chk({15'h0000, n >= 100}, 16'h0001);
    rd(8'h08, d);
    chk(d, 16'h0002);
  endtask

  // Window code 0 keeps the first three quarters closed
  task automatic scen_closed_then_open();
    wr(8'h00, 16'h0090);
    wr(8'h04, 16'h00AC);
    @(negedge clk);
    chk({15'h0000, wdt_reset}, 16'h0001);
    rd(8'h08, d);
    chk(d, 16'h0004);
    wait_sig(1'b0, 420, n);
    wr(8'h04, 16'h00AC);
    @(negedge clk);
    chk({15'h0000, wdt_reset}, 16'h0000);
    rd(8'h08, d);
    chk(d, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    rd(8'h10, d);
    chk({4'h0, d[15:4]}, 16'h0000);
  endtask

  task automatic scen_standby();
    wr(8'h00, 16'h0000);
    standby <= 1'b1;
    wr(8'h04, 16'h00AC);
    @(negedge clk);
    chk({15'h0000, wdt_reset}, 16'h0000);
    rd(8'h10, keep);
    repeat (40) @(posedge clk);
    rd(8'h10, d);
    chk(d, keep);
    wr(8'h00, 16'h0010);
    repeat (40) @(posedge clk);
    rd(8'h10, d);
    chk({15'h0000, d !== keep}, 16'h0001);
    @(posedge clk);
    standby <= 1'b0;
  endtask

  // Reset in mid-run drops a pending interrupt and restores defaults
  task automatic scen_mid_reset();
    wr(8'h0C, 16'h0004);
    wr(8'h00, 16'h0090);
    wr(8'h04, 16'h00AC);
    @(negedge clk);
    chk({15'h0000, irq}, 16'h0001);
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk({14'h0000, irq, wdt_reset}, 16'h0000);
    rd(8'h00, d);
    chk(d, 16'h0077);
    rd(8'h0C, d);
    chk(d, 16'h0000);
    rd(8'h08, d);
    chk(d, 16'h0000);
  endtask

  // Window code 2 keeps only the first quarter closed
  task automatic scen_window_quarter();
    wr(8'h00, 16'h00D0);
    wr(8'h04, 16'h00AC);
    @(negedge clk);
    chk({15'h0000, wdt_reset}, 16'h0001);
    // Just past a quarter of 64 ticks, far from overflow
    repeat (140) @(posedge clk);
    wr(8'h04, 16'h00AC);
    @(negedge clk);
    chk({15'h0000, wdt_reset}, 16'h0000);
    rd(8'h08, d);
    chk(d, 16'h0004);
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    scen_reset_values();
    scen_interval_overflow();
    scen_closed_then_open();
    scen_standby();
    scen_mid_reset();
    scen_window_quarter();
    print_verdict();
  end
endmodule
`default_nettype wire
